// >>> verilog/lccr_defines.vh
// constants of the lane conditioning configuration register bank
// assumes inclusion by the design files that use its constants, by bare name
`ifndef LCCR_DEFINES_VH
`define LCCR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define LCCR_ADDR_EMPH_A0 8'h2E
`define LCCR_ADDR_THRESH_A0 8'h2F
`define LCCR_ADDR_IDLE_RATE_A1 8'h32
`define LCCR_ADDR_EQ_A1 8'h33
`define LCCR_ADDR_SWING_A1 8'h34

////////////////////////////////////////////////////////////////////////////////
// reset values
`define LCCR_RST_EMPH 8'h03
`define LCCR_RST_THRESH 4'h0
`define LCCR_RST_IDLE_RATE 6'h00
`define LCCR_RST_EQ 6'h20
`define LCCR_RST_SWING 6'h03

////////////////////////////////////////////////////////////////////////////////
// field positions
`define LCCR_EMPH_TYPE_BIT 7
`define LCCR_THR_DEASSERT_HI 3
`define LCCR_THR_DEASSERT_LO 2
`define LCCR_THR_ASSERT_HI 1
`define LCCR_THR_ASSERT_LO 0
`define LCCR_IDLE_AUTO_BIT 5
`define LCCR_IDLE_SEL_BIT 4
`define LCCR_RATE_AUTO_BIT 1
`define LCCR_RATE_SEL_BIT 0
`define LCCR_EQ_EN_BIT 5
`define LCCR_EQ_GST_HI 4
`define LCCR_EQ_GST_LO 3
`define LCCR_EQ_BST_HI 2
`define LCCR_EQ_BST_LO 0

////////////////////////////////////////////////////////////////////////////////
// emphasis codes and magnitudes in tenths of a dB
`define LCCR_EMPH_0DB 8'h01
`define LCCR_EMPH_3P5DB 8'h38
`define LCCR_EMPH_6DB 8'h88
`define LCCR_EMPH_9DB 8'h90
`define LCCR_EMPH_12DB 8'hA0
`define LCCR_EMPH_RSVD 8'hC0
`define LCCR_DB10_0 8'h00
`define LCCR_DB10_3P5 8'h23
`define LCCR_DB10_6 8'h3C
`define LCCR_DB10_9 8'h5A
`define LCCR_DB10_12 8'h78

////////////////////////////////////////////////////////////////////////////////
// idle threshold levels in mV
`define LCCR_THR_MV_110 8'h6E
`define LCCR_THR_MV_70 8'h46
`define LCCR_THR_MV_150 8'h96
`define LCCR_THR_MV_170 8'hAA
`define LCCR_THR_MV_130 8'h82
`define LCCR_THR_MV_190 8'hBE

////////////////////////////////////////////////////////////////////////////////
// equalizer codes
`define LCCR_EQ_BYPASS 6'h20
`define LCCR_EQ_2A 6'h2A
`define LCCR_EQ_30 6'h30
`define LCCR_EQ_31 6'h31
`define LCCR_EQ_38 6'h38
`define LCCR_EQ_34 6'h34
`define LCCR_EQ_35 6'h35
`define LCCR_EQ_3A 6'h3A
`define LCCR_EQ_3C 6'h3C

////////////////////////////////////////////////////////////////////////////////
// output swing codes and levels in mV
`define LCCR_SWING_600 6'h03
`define LCCR_SWING_800 6'h07
`define LCCR_SWING_1000 6'h0F
`define LCCR_SWING_1200 6'h1F
`define LCCR_SWING_1400 6'h3F
`define LCCR_MV_600 11'h258
`define LCCR_MV_800 11'h320
`define LCCR_MV_1000 11'h3E8
`define LCCR_MV_1200 11'h4B0
`define LCCR_MV_1400 11'h578

////////////////////////////////////////////////////////////////////////////////
// tri-level strap pin codes and strap timing
`define LCCR_PIN_LO 2'b00
`define LCCR_PIN_HI 2'b01
`define LCCR_PIN_FLT 2'b10
`define LCCR_STRAP_WAIT 2'h2

`endif

// >>> verilog/lccr_sync.v
// two flip-flop synchroniser for a group of pin inputs
// assumes one clock, a synchronous active-low reset and a clock enable
`timescale 1ns/1ps
`default_nettype none

module lccr_sync #(
  parameter WIDTH = 1
) (
  input wire ref_clk_i, // block clock
  input wire rst_n_i, // synchronous reset, active low
  input wire ce_i, // clock enable
  input wire [WIDTH-1:0] async_i, // pin levels
  output wire [WIDTH-1:0] sync_o // synchronised levels
);

  ////////////////////////////////////////////////////////////////////////////////
  // one pair of flops per bit
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_q;
      reg stable_q;
      // first stage only feeds the second
      always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else if (ce_i) begin
          meta_q <= async_i[gi];
          stable_q <= meta_q;
        end
      end
      assign sync_o[gi] = stable_q;
    end
  endgenerate

endmodule // lccr_sync

`default_nettype wire

// >>> verilog/lccr_strap_map.v
// strap pin codes to emphasis byte and equalizer field
// assumes synchronised tri-level codes, purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "lccr_defines.vh"

module lccr_strap_map (
  input wire [1:0] emphasis_strap_high_i, // high emphasis strap level
  input wire [1:0] emphasis_strap_low_i, // low emphasis strap level
  input wire [1:0] boost_strap_first_i, // first boost strap level
  input wire [1:0] boost_strap_second_i, // second boost strap level
  output reg [7:0] emphasis_byte_o, // mapped emphasis byte
  output reg [5:0] boost_byte_o // mapped equalizer field
);

  ////////////////////////////////////////////////////////////////////////////////
  // emphasis strap pair to register value
  always @* begin
    case ({emphasis_strap_high_i, emphasis_strap_low_i})
      {`LCCR_PIN_LO, `LCCR_PIN_LO}: emphasis_byte_o = `LCCR_EMPH_0DB;
      {`LCCR_PIN_LO, `LCCR_PIN_HI}: emphasis_byte_o = `LCCR_EMPH_3P5DB;
      {`LCCR_PIN_LO, `LCCR_PIN_FLT}: emphasis_byte_o = `LCCR_EMPH_6DB;
      {`LCCR_PIN_HI, `LCCR_PIN_LO}: emphasis_byte_o = `LCCR_EMPH_9DB;
      {`LCCR_PIN_HI, `LCCR_PIN_FLT}: emphasis_byte_o = `LCCR_EMPH_12DB;
      {`LCCR_PIN_FLT, `LCCR_PIN_LO}: emphasis_byte_o = `LCCR_EMPH_9DB;
      {`LCCR_PIN_FLT, `LCCR_PIN_HI}: emphasis_byte_o = `LCCR_EMPH_12DB;
      {`LCCR_PIN_FLT, `LCCR_PIN_FLT}: emphasis_byte_o = `LCCR_EMPH_RSVD;
      default: emphasis_byte_o = `LCCR_EMPH_0DB;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // boost strap pair to equalizer field
  always @* begin
    case ({boost_strap_first_i, boost_strap_second_i})
      {`LCCR_PIN_FLT, `LCCR_PIN_FLT}: boost_byte_o = `LCCR_EQ_BYPASS;
      {`LCCR_PIN_HI, `LCCR_PIN_HI}: boost_byte_o = `LCCR_EQ_2A;
      {`LCCR_PIN_LO, `LCCR_PIN_LO}: boost_byte_o = `LCCR_EQ_30;
      {`LCCR_PIN_LO, `LCCR_PIN_FLT}: boost_byte_o = `LCCR_EQ_31;
      {`LCCR_PIN_LO, `LCCR_PIN_HI}: boost_byte_o = `LCCR_EQ_38;
      {`LCCR_PIN_HI, `LCCR_PIN_FLT}: boost_byte_o = `LCCR_EQ_34;
      {`LCCR_PIN_HI, `LCCR_PIN_LO}: boost_byte_o = `LCCR_EQ_35;
      {`LCCR_PIN_FLT, `LCCR_PIN_LO}: boost_byte_o = `LCCR_EQ_3A;
      {`LCCR_PIN_FLT, `LCCR_PIN_HI}: boost_byte_o = `LCCR_EQ_3C;
      default: boost_byte_o = `LCCR_EQ_BYPASS;
    endcase
  end

endmodule // lccr_strap_map

`default_nettype wire

// >>> verilog/lccr_top.v
// configuration register bank for one output and one input lane pair
// assumes a management engine on the same clock drives the register port
// assumes strap pins are static and sampled once after reset release
`timescale 1ns/1ps
`default_nettype none
`include "lccr_defines.vh"

module lccr_top (
  input wire ref_clk_i, // 50 MHz block clock
  input wire rst_n_i, // synchronous reset, active low
  input wire ce_i, // clock enable, freezes state when low
  input wire [7:0] reg_addr_i, // register address
  input wire [7:0] reg_wdata_i, // write data
  input wire reg_wr_i, // write strobe
  input wire reg_rd_i, // read strobe
  output reg [7:0] reg_rdata_o, // read data
  output reg reg_rd_valid_o, // read data valid pulse
  input wire strap_mode_i, // pin: load settings from straps
  input wire [1:0] emphasis_strap_high_i, // pin: tri-level code
  input wire [1:0] emphasis_strap_low_i, // pin: tri-level code
  input wire [1:0] boost_strap_first_i, // pin: tri-level code
  input wire [1:0] boost_strap_second_i, // pin: tri-level code
  output reg emphasis_enhanced_o, // lane a0 enhanced emphasis style
  output reg [6:0] tx_emphasis_level_o, // lane a0 emphasis level field
  output reg [7:0] emphasis_db10_o, // lane a0 emphasis magnitude, 0.1 dB
  output reg emphasis_valid_o, // lane a0 emphasis code is defined
  output reg [7:0] idle_deassert_mv_o, // lane a0 de-assert level, mV
  output reg [7:0] idle_assert_mv_o, // lane a0 assert level, mV
  output reg idle_auto_o, // lane a1 automatic idle detect
  output reg signal_presence_detect_en_o, // lane a1 detector enabled
  output reg output_mute_o, // lane a1 output forced to idle
  output reg rate_auto_o, // lane a1 automatic rate detect
  output reg rate_high_band_o, // lane a1 manual 5.0-6.4 Gbps band
  output reg eq_enable_o, // lane a1 equalizer enable
  output reg [1:0] gain_stage_field_o, // lane a1 gain stage
  output reg [2:0] boost_level_field_o, // lane a1 boost level
  output reg eq_bypass_o, // lane a1 equalizer bypassed
  output reg [10:0] output_swing_mv_o, // lane a1 swing, mV
  output reg output_swing_valid_o // lane a1 swing code is defined
);

  ////////////////////////////////////////////////////////////////////////////////
  // strap synchronisers and mapping
  wire [8:0] pins_raw;
  wire [8:0] pins_sync;
  wire [7:0] strap_emph;
  wire [5:0] strap_boost;
  assign pins_raw = {strap_mode_i, emphasis_strap_high_i, emphasis_strap_low_i,
                     boost_strap_first_i, boost_strap_second_i};

  lccr_sync #(
    .WIDTH(9)
  ) lccr_sync_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );

  lccr_strap_map lccr_strap_map_i (
    .emphasis_strap_high_i(pins_sync[7:6]),
    .emphasis_strap_low_i(pins_sync[5:4]),
    .boost_strap_first_i(pins_sync[3:2]),
    .boost_strap_second_i(pins_sync[1:0]),
    .emphasis_byte_o(strap_emph),
    .boost_byte_o(strap_boost)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // strap load sequencer: waits for synchronisers to settle
  localparam ST_WAIT = 2'b01;
  localparam ST_DONE = 2'b10;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] wait_cnt_q;
  reg strap_load;

  // next state and one-cycle load strobe
  always @* begin
    state_d = state_q;
    strap_load = 1'b0;
    case (state_q)
      ST_WAIT: begin
        if (wait_cnt_q == `LCCR_STRAP_WAIT) begin
          state_d = ST_DONE;
          strap_load = pins_sync[8];
        end
      end
      ST_DONE: state_d = ST_DONE;
      default: state_d = ST_WAIT;
    endcase
  end

  // sequencer flops
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_WAIT;
      wait_cnt_q <= 2'h0;
    end else if (ce_i) begin
      state_q <= state_d;
      if (state_q == ST_WAIT && wait_cnt_q != `LCCR_STRAP_WAIT) begin
        wait_cnt_q <= wait_cnt_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register storage
  reg [7:0] emph_q;
  reg [3:0] thresh_q;
  reg [5:0] idle_rate_q;
  reg [5:0] eq_q;
  reg [5:0] swing_q;
  wire wr_emph;
  wire wr_thresh;
  wire wr_idle_rate;
  wire wr_eq;
  wire wr_swing;
  assign wr_emph = reg_wr_i && reg_addr_i == `LCCR_ADDR_EMPH_A0;
  assign wr_thresh = reg_wr_i && reg_addr_i == `LCCR_ADDR_THRESH_A0;
  assign wr_idle_rate = reg_wr_i && reg_addr_i == `LCCR_ADDR_IDLE_RATE_A1;
  assign wr_eq = reg_wr_i && reg_addr_i == `LCCR_ADDR_EQ_A1;
  assign wr_swing = reg_wr_i && reg_addr_i == `LCCR_ADDR_SWING_A1;

  // software write wins over a strap load in the same cycle
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      emph_q <= `LCCR_RST_EMPH;
      thresh_q <= `LCCR_RST_THRESH;
      idle_rate_q <= `LCCR_RST_IDLE_RATE;
      eq_q <= `LCCR_RST_EQ;
      swing_q <= `LCCR_RST_SWING;
    end else if (ce_i) begin
      if (wr_emph) begin
        emph_q <= reg_wdata_i;
      end else if (strap_load) begin
        emph_q <= strap_emph;
      end
      if (wr_thresh) begin
        thresh_q <= reg_wdata_i[3:0];
      end
      if (wr_idle_rate) begin
        idle_rate_q <= {reg_wdata_i[5:4], 2'b00, reg_wdata_i[1:0]};
      end
      if (wr_eq) begin
        eq_q <= reg_wdata_i[5:0];
      end else if (strap_load) begin
        eq_q <= strap_boost;
      end
      if (wr_swing) begin
        swing_q <= reg_wdata_i[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path: one cycle latency, unmapped reads as zero
  reg [7:0] rdata_d;
  always @* begin
    case (reg_addr_i)
      `LCCR_ADDR_EMPH_A0: rdata_d = emph_q;
      `LCCR_ADDR_THRESH_A0: rdata_d = {4'h0, thresh_q};
      `LCCR_ADDR_IDLE_RATE_A1: rdata_d = {2'b00, idle_rate_q};
      `LCCR_ADDR_EQ_A1: rdata_d = {2'b00, eq_q};
      `LCCR_ADDR_SWING_A1: rdata_d = {2'b00, swing_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // read data held until next read
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_rd_valid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rd_valid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // emphasis decode; reserved C0h is left to software to avoid
  reg [7:0] db10_d;
  reg emph_ok_d;
  always @* begin
    emph_ok_d = 1'b1;
    case (emph_q)
      `LCCR_EMPH_0DB: db10_d = `LCCR_DB10_0;
      `LCCR_EMPH_3P5DB: db10_d = `LCCR_DB10_3P5;
      `LCCR_EMPH_6DB: db10_d = `LCCR_DB10_6;
      `LCCR_EMPH_9DB: db10_d = `LCCR_DB10_9;
      `LCCR_EMPH_12DB: db10_d = `LCCR_DB10_12;
      default: begin
        db10_d = `LCCR_DB10_0;
        emph_ok_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // idle threshold level pairs
  function [15:0] lccr_thr_pair;
    input [1:0] code;
    begin
      case (code)
        2'b00: lccr_thr_pair = {`LCCR_THR_MV_110, `LCCR_THR_MV_70};
        2'b01: lccr_thr_pair = {`LCCR_THR_MV_150, `LCCR_THR_MV_110};
        2'b10: lccr_thr_pair = {`LCCR_THR_MV_170, `LCCR_THR_MV_130};
        default: lccr_thr_pair = {`LCCR_THR_MV_190, `LCCR_THR_MV_150};
      endcase
    end
  endfunction

  wire [15:0] deassert_pair;
  wire [15:0] assert_pair;
  assign deassert_pair = lccr_thr_pair(thresh_q[`LCCR_THR_DEASSERT_HI:`LCCR_THR_DEASSERT_LO]);
  assign assert_pair = lccr_thr_pair(thresh_q[`LCCR_THR_ASSERT_HI:`LCCR_THR_ASSERT_LO]);

  ////////////////////////////////////////////////////////////////////////////////
  // output swing decode
  reg [10:0] swing_mv_d;
  reg swing_ok_d;
  always @* begin
    swing_ok_d = 1'b1;
    case (swing_q)
      `LCCR_SWING_600: swing_mv_d = `LCCR_MV_600;
      `LCCR_SWING_800: swing_mv_d = `LCCR_MV_800;
      `LCCR_SWING_1000: swing_mv_d = `LCCR_MV_1000;
      `LCCR_SWING_1200: swing_mv_d = `LCCR_MV_1200;
      `LCCR_SWING_1400: swing_mv_d = `LCCR_MV_1400;
      default: begin
        swing_mv_d = `LCCR_MV_600;
        swing_ok_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered control outputs to the analog lanes
  wire idle_auto;
  assign idle_auto = idle_rate_q[`LCCR_IDLE_AUTO_BIT];
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      emphasis_enhanced_o <= 1'b0;
      tx_emphasis_level_o <= 7'h03;
      emphasis_db10_o <= `LCCR_DB10_0;
      emphasis_valid_o <= 1'b0;
      idle_deassert_mv_o <= `LCCR_THR_MV_110;
      idle_assert_mv_o <= `LCCR_THR_MV_70;
      idle_auto_o <= 1'b0;
      signal_presence_detect_en_o <= 1'b0;
      output_mute_o <= 1'b0;
      rate_auto_o <= 1'b0;
      rate_high_band_o <= 1'b0;
      eq_enable_o <= 1'b1;
      gain_stage_field_o <= 2'b00;
      boost_level_field_o <= 3'b000;
      eq_bypass_o <= 1'b1;
      output_swing_mv_o <= `LCCR_MV_600;
      output_swing_valid_o <= 1'b1;
    end else if (ce_i) begin
      emphasis_enhanced_o <= emph_q[`LCCR_EMPH_TYPE_BIT];
      tx_emphasis_level_o <= emph_q[6:0];
      emphasis_db10_o <= db10_d;
      emphasis_valid_o <= emph_ok_d;
      idle_deassert_mv_o <= deassert_pair[15:8];
      idle_assert_mv_o <= assert_pair[7:0];
      idle_auto_o <= idle_auto;
      // manual mode: detector off, mute follows select bit
      signal_presence_detect_en_o <= idle_auto;
      output_mute_o <= !idle_auto && idle_rate_q[`LCCR_IDLE_SEL_BIT];
      rate_auto_o <= idle_rate_q[`LCCR_RATE_AUTO_BIT];
      rate_high_band_o <= !idle_rate_q[`LCCR_RATE_AUTO_BIT] &&
                          idle_rate_q[`LCCR_RATE_SEL_BIT];
      eq_enable_o <= eq_q[`LCCR_EQ_EN_BIT];
      gain_stage_field_o <= eq_q[`LCCR_EQ_GST_HI:`LCCR_EQ_GST_LO];
      boost_level_field_o <= eq_q[`LCCR_EQ_BST_HI:`LCCR_EQ_BST_LO];
      eq_bypass_o <= eq_q == `LCCR_EQ_BYPASS;
      output_swing_mv_o <= swing_mv_d;
      output_swing_valid_o <= swing_ok_d;
    end
  end

endmodule // lccr_top

`default_nettype wire

// >>> verification/lccr_top_monitor.sv
// checker of the lane conditioning register bank, watching top ports only
// assumes one block clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module lccr_top_monitor (
  input wire logic ref_clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic ce_i, // clock enable
  input wire logic [7:0] reg_addr_i, // address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [7:0] reg_rdata_o, // read data
  input wire logic reg_rd_valid_o, // read valid
  input wire logic emphasis_enhanced_o, // emphasis style
  input wire logic [6:0] tx_emphasis_level_o, // emphasis level
  input wire logic [7:0] emphasis_db10_o, // emphasis magnitude
  input wire logic emphasis_valid_o, // emphasis code defined
  input wire logic [7:0] idle_deassert_mv_o, // de-assert level
  input wire logic [7:0] idle_assert_mv_o, // assert level
  input wire logic idle_auto_o, // automatic idle
  input wire logic output_mute_o, // output muted
  input wire logic eq_enable_o, // equalizer on
  input wire logic [1:0] gain_stage_field_o, // gain stage
  input wire logic [2:0] boost_level_field_o, // boost level
  input wire logic eq_bypass_o, // equalizer bypass
  input wire logic [10:0] output_swing_mv_o, // swing level
  input wire logic output_swing_valid_o // swing code defined
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // write taken at one edge, clock still enabled at the next
  sequence s_wr(logic [7:0] a, logic [7:0] m, logic [7:0] v);
    ce_i && reg_wr_i && reg_addr_i == a && (reg_wdata_i & m) == v ##1 ce_i;
  endsequence

  ////////////////////////////////////////
  // register port handshake
  a_rd_answer:
    assert property (ce_i && reg_rd_i |=> reg_rd_valid_o) else $error("read not answered");
  a_rd_pulse:
    assert property (reg_rd_valid_o && $past(ce_i) |-> $past(reg_rd_i))
      else $error("read valid without read");
  a_rdata_holds:
    assert property (!reg_rd_valid_o && $past(rst_n_i) |-> $stable(reg_rdata_o))
      else $error("read data moved without read");
  a_unmapped_read:
    assert property (ce_i && reg_rd_i && !(reg_addr_i inside {8'h2E, 8'h2F, 8'h32, 8'h33,
      8'h34}) |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");

  ////////////////////////////////////////
  // decoded controls follow written values
  a_emph_style:
    assert property (s_wr(8'h2E, 8'h00, 8'h00) |=> emphasis_enhanced_o == $past(reg_wdata_i[7], 2)
      && tx_emphasis_level_o == $past(reg_wdata_i[6:0], 2)) else $error("emphasis fields wrong");
  a_emph_decode:
    assert property (s_wr(8'h2E, 8'hFF, 8'hA0) |=> emphasis_db10_o == 8'h78 && emphasis_valid_o)
      else $error("emphasis decode wrong");
  a_thresh_top:
    assert property (s_wr(8'h2F, 8'h0F, 8'h0F) |=> idle_deassert_mv_o == 8'hBE
      && idle_assert_mv_o == 8'h96) else $error("threshold levels wrong");
  a_idle_manual:
    assert property (s_wr(8'h32, 8'h30, 8'h10) |=> output_mute_o && !idle_auto_o)
      else $error("manual idle not muted");
  a_eq_fields:
    assert property (s_wr(8'h33, 8'h00, 8'h00) |=> {eq_enable_o, gain_stage_field_o,
      boost_level_field_o} == $past(reg_wdata_i[5:0], 2)
      && eq_bypass_o == ($past(reg_wdata_i[5:0], 2) == 6'h20)) else $error("eq fields wrong");
  a_swing_top:
    assert property (s_wr(8'h34, 8'h3F, 8'h3F) |=> output_swing_mv_o == 11'h578
      && output_swing_valid_o) else $error("swing decode wrong");
endmodule // lccr_top_monitor

bind lccr_top lccr_top_monitor lccr_top_monitor_i (.*);

`default_nettype wire

// >>> verification/lccr_top_tb.sv
// self-checking bench of the lane conditioning register bank
// assumes the design and its bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module lccr_top_tb;
  logic ref_clk_i, rst_n_i, ce_i, reg_wr_i, reg_rd_i, strap_mode_i;
  logic [7:0] reg_addr_i, reg_wdata_i;
  logic [1:0] emphasis_strap_high_i, emphasis_strap_low_i;
  logic [1:0] boost_strap_first_i, boost_strap_second_i;
  wire [7:0] reg_rdata_o, emphasis_db10_o, idle_deassert_mv_o, idle_assert_mv_o;
  wire [6:0] tx_emphasis_level_o;
  wire [1:0] gain_stage_field_o;
  wire [2:0] boost_level_field_o;
  wire [10:0] output_swing_mv_o;
  wire reg_rd_valid_o, emphasis_enhanced_o, emphasis_valid_o, idle_auto_o, output_mute_o;
  wire signal_presence_detect_en_o, rate_auto_o, rate_high_band_o, eq_enable_o, eq_bypass_o;
  wire output_swing_valid_o;
  int bad_count = 0;
  int n_tests = 0;
  int i;
  logic [7:0] got;
  logic [47:0] rows [0:22];
  logic [39:0] rst_tab [0:4];
  logic [23:0] strap_tab [0:8];

  lccr_top lccr_top_i (.*);

  // 50 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////
  // decoded outputs of one register, packed
  function automatic [23:0] obs(input [7:0] a);
    case (a)
      8'h2E: obs = {7'h0, emphasis_valid_o, emphasis_enhanced_o, tx_emphasis_level_o,
        emphasis_db10_o};
      8'h2F: obs = {8'h00, idle_deassert_mv_o, idle_assert_mv_o};
      8'h32: obs = {19'h0, idle_auto_o, signal_presence_detect_en_o, output_mute_o, rate_auto_o,
        rate_high_band_o};
      8'h33: obs = {17'h0, eq_enable_o, gain_stage_field_o, boost_level_field_o, eq_bypass_o};
      8'h34: obs = {12'h0, output_swing_valid_o, output_swing_mv_o};
      default: obs = 24'h000000;
    endcase
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic fail(input string msg);
    $display("CHECK FAILED at %0t: %s", $time, msg);
    bad_count++;
  endtask

  task automatic chk_rd(input [7:0] g, input [7:0] e);
    n_tests++;
    if (g !== e)
      fail($sformatf("read %h expected %h", g, e));
  endtask

  task automatic chk_obs(input [7:0] a, input [23:0] e, input [23:0] m);
    n_tests++;
    if ((obs(a) & m) !== e)
      fail($sformatf("outputs of %h are %h expected %h", a, obs(a), e));
  endtask

  ////////////////////////////////////////
  // register port drivers
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input [7:0] a);
    int n;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    n = 0;
    while (reg_rd_valid_o !== 1'b1 && n < 4) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n == 4) begin
      fail("read answer timed out");
      conclude();
    end
    got = reg_rdata_o;
  endtask

  task automatic do_reset();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
  endtask

  // every register and its outputs at reset values
  task automatic chk_reset();
    for (int k = 0; k < 5; k++) begin
      rd(rst_tab[k][39:32]);
      chk_rd(got, rst_tab[k][31:24]);
      chk_obs(rst_tab[k][39:32], rst_tab[k][23:0], 24'hFFFFFF);
    end
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    strap_mode_i = 1'b0;
    {emphasis_strap_high_i, emphasis_strap_low_i} = 4'h0;
    {boost_strap_first_i, boost_strap_second_i} = 4'h0;
    // address, write data, read-back, packed outputs
    rows = '{48'h2E0101010100, 48'h2E3838013823, 48'h2E888801883C, 48'h2E909001905A,
      48'h2EA0A001A078, 48'h2F050500966E, 48'h2F0A0A00AA82, 48'h2F0F0F00BE96,
      48'h2FF303006E96, 48'h2F0C0C00BE46, 48'h321010000004, 48'h323030000018,
      48'h320101000001, 48'h32FF3300001A, 48'h333C3C000078, 48'h332A2A000054,
      48'h33070700000E, 48'h33FF3F00007E, 48'h332020000041, 48'h340707000B20,
      48'h34C505000258, 48'h343F3F000D78, 48'h305500000000};
    rst_tab = '{40'h2E03000300, 40'h2F00006E46, 40'h3200000000, 40'h3320000041,
      40'h3403000A58};
    // strap levels, expected emphasis byte, expected equalizer byte
    strap_tab = '{24'h0A0120, 24'h15382A, 24'h208830, 24'h429031, 24'h510138,
      24'h66A034, 24'h849035, 24'h98A03A, 24'hA9C03C};
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    chk_reset();
    for (i = 0; i < 23; i++) begin
      wr(rows[i][47:40], rows[i][39:32]);
      @(posedge ref_clk_i);
      #1;
      chk_obs(rows[i][47:40], rows[i][23:0], 24'hFFFFFF);
      rd(rows[i][47:40]);
      chk_rd(got, rows[i][31:24]);
    end
    // reserved emphasis code is stored but not decoded
    wr(8'h2E, 8'hC0);
    rd(8'h2E);
    chk_rd(got, 8'hC0);
    chk_obs(8'h2E, 24'h00C000, 24'hFFFF00);
    // reset in mid-run restores defaults
    do_reset();
    chk_reset();
    // frozen clock enable drops a write
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    wr(8'h33, 8'h07);
    ce_i <= 1'b1;
    rd(8'h33);
    chk_rd(got, 8'h20);
    // strap pins load emphasis and equalizer after reset
    for (i = 0; i < 9; i++) begin
      @(posedge ref_clk_i);
      {emphasis_strap_high_i, emphasis_strap_low_i} <= strap_tab[i][23:20];
      {boost_strap_first_i, boost_strap_second_i} <= strap_tab[i][19:16];
      strap_mode_i <= 1'b1;
      do_reset();
      repeat (8) @(posedge ref_clk_i);
      rd(8'h2E);
      chk_rd(got, strap_tab[i][15:8]);
      rd(8'h33);
      chk_rd(got, strap_tab[i][7:0]);
    end
    strap_mode_i <= 1'b0;
    conclude();
  end
endmodule // lccr_top_tb

`default_nettype wire
